// >>> hdl/smram_access_decode.sv
/*
 File holds the SMRAM access decoder with its two control registers.
 Assumes host requests and config writes come from logic on I_CLK_SYS.
*/
// What this block does
// - Global enable exposes 128 KB at A0000h in SMM
// - Extended functions, except TSEG hiding, need global enable set
// - Lock freezes global, high, size, TSEG enable
// - Base segment reads 010, writes ignored
// - Compat DRAM not remapped, else hub
// - High window FEDA0000h remaps to A0000h
// - Non-SMM extended access, open clear, sets error
// - Error clears only by writing one
// - Cache and level enable bits read one
// - Size field selects 128K to 1M
// - Enabled TSEG not claimed as ordinary memory
// - TSEG appears only with both enables
// - Extended space is write-back cacheable
// - Lock set by write, forces open zero
// - Open and unlocked shows SMM DRAM unless closed blocks data
// - Closed blocks compat data, allows code references
// - Open, closed, lock need global enable
`default_nettype none
module smram_access_decode
   import smram_pkg::*;
(
   // Clock, reset, enable
   input wire logic I_CLK_SYS,
   input wire logic I_NRST,
   input wire logic I_CE,
   // Configuration port
   input wire logic I_CFG_WR,
   input wire logic [7:0] I_CFG_ADDR,
   input wire logic [7:0] I_CFG_WDATA,
   output logic [7:0] O_CFG_RDATA,
   // Memory layout
   input wire logic [31:0] I_TOP_OF_MEMORY,
   // Host request
   input wire host_req_s I_HOST_REQ,
   // Decode result
   output decode_res_s O_DECODE,
   output logic O_WB_CACHEABLE,
   output logic O_EXT_ERROR
);
   logic smm_open_q, smm_closed_q, smm_lock_q, global_en_q;
   logic high_en_q, err_q, top_segment_enable_q;
   logic [1:0] tseg_size_q;
   logic [7:0] rdata_q;
   decode_res_s dec_q;
   logic cache_q;

   wire wr_smc = I_CE && I_CFG_WR && (I_CFG_ADDR == SMRAM_CONTROL_OFS);
   wire wr_ext = I_CE && I_CFG_WR && (I_CFG_ADDR == EXT_SMRAM_CONTROL_OFS);
   // Lock and open act only under global enable
   wire lock_eff = smm_lock_q && global_en_q;
   wire open_eff = smm_open_q && !smm_lock_q && global_en_q;
   wire closed_eff = smm_closed_q && global_en_q;

   wire [31:0] a = I_HOST_REQ.addr;
   wire [31:0] tseg_len = TSEG_128K << tseg_size_q;
   wire [31:0] tseg_base = I_TOP_OF_MEMORY - tseg_len;
   wire in_compat = (a >= COMPAT_BASE) && (a <= COMPAT_LAST);
   wire in_high = (a >= HIGH_BASE) && (a <= HIGH_LAST);
   wire in_tseg = (a >= tseg_base) && (a < I_TOP_OF_MEMORY);
   wire high_on = global_en_q && high_en_q;
   wire tseg_on = global_en_q && top_segment_enable_q;
   wire smm_ok = I_HOST_REQ.smm || open_eff;
   wire compat_hit = global_en_q && in_compat && smm_ok
      && !(closed_eff && !I_HOST_REQ.code);
   wire high_hit = high_on && in_high && smm_ok;
   wire tseg_hit = tseg_on && in_tseg && smm_ok;
   wire ext_hit = high_hit || tseg_hit;
   wire ext_viol = I_HOST_REQ.valid && !I_HOST_REQ.smm && !open_eff
      && ((high_on && in_high) || (tseg_on && in_tseg));
   // TSEG range is not ordinary memory while enabled
   wire ordinary = (a < I_TOP_OF_MEMORY) && !in_compat && !(top_segment_enable_q && in_tseg)
      && !in_high;
   wire to_dram = compat_hit || ext_hit || ordinary;
   wire [31:0] dram_addr = high_hit ? (a - HIGH_BASE + COMPAT_BASE) : a;

   wire [7:0] smc_rd = {1'b0, smm_open_q, smm_closed_q, smm_lock_q, global_en_q,
      COMPAT_BASE_SEG_VAL};
   wire [7:0] ext_rd = {high_en_q, err_q, CACHE_BITS_VAL, tseg_size_q,
      top_segment_enable_q};
   wire [7:0] rd_mux = (I_CFG_ADDR == SMRAM_CONTROL_OFS) ? smc_rd :
      (I_CFG_ADDR == EXT_SMRAM_CONTROL_OFS) ? ext_rd : 8'h00;

   // smram_control, lock clears only on reset
   always_ff @(posedge I_CLK_SYS) begin
      if (!I_NRST) begin
         smm_open_q <= 1'b0;
         smm_closed_q <= 1'b0;
         smm_lock_q <= 1'b0;
         global_en_q <= 1'b0;
      end else if (wr_smc) begin
         smm_closed_q <= I_CFG_WDATA[CLOSED_BIT];
         if (!lock_eff) begin
            global_en_q <= I_CFG_WDATA[GLOBAL_EN_BIT];
            smm_lock_q <= I_CFG_WDATA[LOCK_BIT] && I_CFG_WDATA[GLOBAL_EN_BIT];
            smm_open_q <= I_CFG_WDATA[OPEN_BIT] && !I_CFG_WDATA[LOCK_BIT];
         end
      end
   end

   // extended_smram_control
   always_ff @(posedge I_CLK_SYS) begin
      if (!I_NRST) begin
         high_en_q <= EXT_SMRAM_CONTROL_RST[HIGH_EN_BIT];
         tseg_size_q <= EXT_SMRAM_CONTROL_RST[TOP_SEGMENT_SIZE_LSB +: 2];
         top_segment_enable_q <= EXT_SMRAM_CONTROL_RST[TOP_SEGMENT_ENABLE_BIT];
         err_q <= EXT_SMRAM_CONTROL_RST[ERR_BIT];
      end else if (I_CE) begin
         if (wr_ext && !lock_eff) begin
            high_en_q <= I_CFG_WDATA[HIGH_EN_BIT];
            tseg_size_q <= I_CFG_WDATA[TOP_SEGMENT_SIZE_LSB +: 2];
            top_segment_enable_q <= I_CFG_WDATA[TOP_SEGMENT_ENABLE_BIT];
         end
         // Set wins over a same-cycle write-one clear
         if (ext_viol)
            err_q <= 1'b1;
         else if (wr_ext && I_CFG_WDATA[ERR_BIT])
            err_q <= 1'b0;
      end
   end

   // Registered outputs
   always_ff @(posedge I_CLK_SYS) begin
      if (!I_NRST) begin
         rdata_q <= 8'h00;
         dec_q <= '0;
         cache_q <= 1'b0;
      end else if (I_CE) begin
         rdata_q <= rd_mux;
         dec_q.valid <= I_HOST_REQ.valid;
         dec_q.route <= !I_HOST_REQ.valid ? ROUTE_NONE : (to_dram ? ROUTE_DRAM : ROUTE_HUB);
         dec_q.dram_addr <= dram_addr;
         cache_q <= I_HOST_REQ.valid && ext_hit && (a >= ONE_MB);
      end
   end

   assign O_CFG_RDATA = rdata_q;
   assign O_DECODE = dec_q;
   assign O_WB_CACHEABLE = cache_q;
   assign O_EXT_ERROR = err_q;

   default clocking cb @(posedge I_CLK_SYS); endclocking
   default disable iff (!I_NRST);

   // Locked write to the extended register
   sequence locked_ext_write_s;
      I_CE && lock_eff && wr_ext;
   endsequence

   // Every lockable extended field keeps its value
   sequence ext_fields_kept_s;
      $stable(high_en_q) && $stable(tseg_size_q) && $stable(top_segment_enable_q);
   endsequence

   // Locked write to smram_control
   sequence locked_smc_write_s;
      lock_eff && wr_smc;
   endsequence

   // Host request into the compatible window
   sequence compat_req_s;
      I_CE && I_HOST_REQ.valid && in_compat;
   endsequence

   // Lock keeps global enable
   chk_lock_holds_global: assert property (
      smm_lock_q && global_en_q && I_CE |=> global_en_q)
      else $error("global enable changed while locked");

   // Lock survives everything but reset
   chk_lock_sticky: assert property (
      smm_lock_q |=> smm_lock_q)
      else $error("lock cleared without reset");

   // Open never stands beside lock
   chk_lock_forces_open: assert property (
      smm_lock_q |-> !smm_open_q)
      else $error("open set while locked");

   // Reads taken in reset show reset data, so skip them
   chk_base_seg_read: assert property (
      $past(I_NRST) && $past(I_CE) && $past(I_CFG_ADDR) == SMRAM_CONTROL_OFS
      |-> O_CFG_RDATA[2:0] == 3'h2)
      else $error("base segment not 010");

   chk_cache_bits_read: assert property (
      $past(I_NRST) && $past(I_CE) && $past(I_CFG_ADDR) == EXT_SMRAM_CONTROL_OFS
      |-> O_CFG_RDATA[5:3] == 3'h7)
      else $error("cache bits not one");

   // Violation raises the flag next cycle
   chk_error_sets: assert property (
      I_CE && ext_viol |=> O_EXT_ERROR)
      else $error("error flag not set");

   chk_error_zero_write: assert property (
      O_EXT_ERROR && !(wr_ext && I_CFG_WDATA[ERR_BIT]) |=> O_EXT_ERROR)
      else $error("error flag lost");

   // Write of one clears when no new violation
   chk_error_clear_one: assert property (
      O_EXT_ERROR && wr_ext && I_CFG_WDATA[ERR_BIT] && !ext_viol
      |=> !O_EXT_ERROR)
      else $error("error flag not cleared by one");

   chk_global_off_compat: assert property (
      I_CE && I_HOST_REQ.valid && !global_en_q && in_compat |=> O_DECODE.route == ROUTE_HUB)
      else $error("compat window claimed while disabled");

   // High window lands on the compatible DRAM range
   chk_high_remap: assert property (
      I_CE && I_HOST_REQ.valid && high_hit |=> O_DECODE.route == ROUTE_DRAM
      && O_DECODE.dram_addr == $past(a) - (HIGH_BASE - COMPAT_BASE))
      else $error("high window remap wrong");

   chk_closed_data: assert property (
      I_CE && I_HOST_REQ.valid && closed_eff && in_compat && !I_HOST_REQ.code
      |=> O_DECODE.route == ROUTE_HUB)
      else $error("closed data access reached dram");

   // Code fetches pass a closed window
   chk_closed_code: assert property (
      compat_req_s ##0 (closed_eff && I_HOST_REQ.code && I_HOST_REQ.smm)
      |=> O_DECODE.route == ROUTE_DRAM)
      else $error("closed code access blocked");

   // Lockable extended fields ignore locked writes
   chk_lock_holds_ext: assert property (
      locked_ext_write_s |=> ext_fields_kept_s)
      else $error("extended field changed while locked");

   chk_lock_holds_lock: assert property (
      locked_smc_write_s |=> smm_lock_q && global_en_q)
      else $error("locked control field changed");

   // Lock cannot be set without global enable
   chk_lock_needs_global: assert property (
      I_CE && wr_smc && !lock_eff && !I_CFG_WDATA[GLOBAL_EN_BIT] |=> !smm_lock_q)
      else $error("lock set without global enable");

   // Setting lock forces open low
   chk_open_cleared_lock: assert property (
      I_CE && wr_smc && !lock_eff && I_CFG_WDATA[LOCK_BIT] |=> !smm_open_q)
      else $error("open survived lock write");

   // Compatible DRAM is shown at its own address
   chk_compat_no_remap: assert property (
      compat_req_s ##0 compat_hit
      |=> O_DECODE.route == ROUTE_DRAM && O_DECODE.dram_addr == $past(a))
      else $error("compat access remapped");

   // Non-SMM access without open goes to the hub
   chk_compat_miss_hub: assert property (
      compat_req_s ##0 (!I_HOST_REQ.smm && !open_eff)
      |=> O_DECODE.route == ROUTE_HUB)
      else $error("compat access claimed outside SMM");

   chk_open_shows_dram: assert property (
      compat_req_s ##0 (open_eff && !closed_eff)
      |=> O_DECODE.route == ROUTE_DRAM)
      else $error("open window not shown");

   // High window needs global enable
   chk_high_needs_global: assert property (
      I_CE && I_HOST_REQ.valid && !global_en_q && in_high
      |=> O_DECODE.route == ROUTE_HUB)
      else $error("high window claimed while disabled");

   // Enabled TSEG is never ordinary memory
   chk_tseg_not_ordinary: assert property (
      I_CE && I_HOST_REQ.valid && top_segment_enable_q && in_tseg
      && !(global_en_q && (I_HOST_REQ.smm || open_eff))
      |=> O_DECODE.route == ROUTE_HUB)
      else $error("tseg claimed as ordinary memory");

   chk_tseg_smm_dram: assert property (
      I_CE && I_HOST_REQ.valid && tseg_on && in_tseg && I_HOST_REQ.smm
      |=> O_DECODE.route == ROUTE_DRAM && O_DECODE.dram_addr == $past(a))
      else $error("tseg not shown in SMM");

   // High window, above 1 MB, is cacheable
   chk_high_cacheable: assert property (
      I_CE && I_HOST_REQ.valid && high_hit |=> O_WB_CACHEABLE)
      else $error("high window not cacheable");

   chk_low_uncached: assert property (
      I_CE && I_HOST_REQ.valid && a < ONE_MB |=> !O_WB_CACHEABLE)
      else $error("space below 1 MB marked cacheable");

   // Decode valid follows the request
   chk_decode_valid: assert property (
      I_CE |=> O_DECODE.valid == $past(I_HOST_REQ.valid))
      else $error("decode valid does not follow request");

   // Low enable freezes read data, decode and error outputs
   chk_ce_freezes: assert property (
      !I_CE |=> $stable(O_CFG_RDATA) && $stable(O_DECODE) && $stable(O_EXT_ERROR))
      else $error("state moved while clock enable low");
endmodule : smram_access_decode
`default_nettype wire

// >>> hdl/smram_pkg.sv
/*
 File holds constants and carrier types for the SMRAM access decoder.
 Assumes a 32-bit host address and a byte-wide configuration port.
*/
`default_nettype none
package smram_pkg;
   localparam logic [7:0] SMRAM_CONTROL_OFS = 8'h9D;
   localparam logic [7:0] EXT_SMRAM_CONTROL_OFS = 8'h9E;
   localparam logic [7:0] SMRAM_CONTROL_RST = 8'h02;
   localparam logic [7:0] EXT_SMRAM_CONTROL_RST = 8'h38;
   // Fields of smram_control
   localparam int OPEN_BIT = 6;
   localparam int CLOSED_BIT = 5;
   localparam int LOCK_BIT = 4;
   localparam int GLOBAL_EN_BIT = 3;
   localparam logic [2:0] COMPAT_BASE_SEG_VAL = 3'h2;
   // Fields of extended_smram_control
   localparam int HIGH_EN_BIT = 7;
   localparam int ERR_BIT = 6;
   localparam logic [2:0] CACHE_BITS_VAL = 3'h7;
   localparam int TOP_SEGMENT_SIZE_LSB = 1;
   localparam int TOP_SEGMENT_ENABLE_BIT = 0;
   // Address windows
   localparam logic [31:0] COMPAT_BASE = 32'h000A_0000;
   localparam logic [31:0] COMPAT_LAST = 32'h000B_FFFF;
   localparam logic [31:0] HIGH_BASE = 32'hFEDA_0000;
   localparam logic [31:0] HIGH_LAST = 32'hFEDB_FFFF;
   localparam logic [31:0] ONE_MB = 32'h0010_0000;
   localparam logic [31:0] TSEG_128K = 32'h0002_0000;

   typedef enum logic [1:0] {
      ROUTE_NONE,
      ROUTE_DRAM,
      ROUTE_HUB
   } route_e;

   typedef struct packed {
      logic valid;
      logic [31:0] addr;
      logic smm;
      logic code;
   } host_req_s;

   typedef struct packed {
      logic valid;
      route_e route;
      logic [31:0] dram_addr;
   } decode_res_s;
endpackage : smram_pkg
`default_nettype wire

// >>> verification/host_model.sv
/*
 Host bus model: presents one request per call for one clock cycle.
 Assumes the caller enters just after a falling edge of the clock.
*/
`default_nettype none
module host_model
   import smram_pkg::*;
(
   input wire logic i_clk,
   output host_req_s o_req
);
   timeunit 1ns;
   timeprecision 1ps;
   initial o_req = '0;
   task automatic issue(input logic [31:0] a, input logic s, input logic c);
      o_req = '{1'b1, a, s, c};
      @(negedge i_clk);
   endtask : issue
   task automatic idle;
      // Released bus shows the inverse, not the last value
      o_req = '{1'b0, ~o_req.addr, ~o_req.smm, ~o_req.code};
      @(negedge i_clk);
   endtask : idle
endmodule : host_model
`default_nettype wire

// >>> verification/test_smram_access_decode.sv
/*
 Self-checking bench for the SMRAM access decoder, one task per scenario.
 Assumes host_model.sv and the design package are compiled first.
*/
`default_nettype none
module test_smram_access_decode
   import smram_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] SC = SMRAM_CONTROL_OFS;
   localparam logic [7:0] EC = EXT_SMRAM_CONTROL_OFS;
   logic clk = 0;
   logic nrst = 0;
   logic ce = 1;
   logic wr = 0;
   logic [7:0] ca = 8'h00;
   logic [7:0] wd = 8'h00;
   logic [7:0] rd;
   logic [31:0] top_of_memory = 32'h1000_0000;
   host_req_s req;
   decode_res_s dec;
   logic wb;
   logic err;
   int n_fail = 0;
   int n_tests = 0;
   always #2 clk = ~clk;
   smram_access_decode smram_access_decode_i (.I_CLK_SYS(clk), .I_NRST(nrst), .I_CE(ce),
      .I_CFG_WR(wr), .I_CFG_ADDR(ca), .I_CFG_WDATA(wd), .O_CFG_RDATA(rd),
      .I_TOP_OF_MEMORY(top_of_memory), .I_HOST_REQ(req), .O_DECODE(dec), .O_WB_CACHEABLE(wb),
      .O_EXT_ERROR(err));
   host_model host_model_i (.i_clk(clk), .o_req(req));
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         $display("mismatch %s exp %h got %h", n, e, g);
         n_fail++;
      end
   endtask : chk
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      ca = a;
      wd = d;
      wr = 1'b1;
      @(negedge clk);
      wr = 1'b0;
      @(negedge clk);
   endtask : wr_reg
   task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
      ca = a;
      @(negedge clk);
      chk("cfg_rdata", {24'h0, e}, {24'h0, rd});
   endtask : rd_reg
   task automatic hreq(input logic [31:0] a, input logic s, input logic c, input route_e r,
      input logic [31:0] da);
      host_model_i.issue(a, s, c);
      chk("decode_valid", 1, {31'h0, dec.valid});
      chk("route", {30'h0, r}, {30'h0, dec.route});
      if (r == ROUTE_DRAM) chk("dram_addr", da, dec.dram_addr);
      host_model_i.idle();
   endtask : hreq
   task automatic s_reset;
      rd_reg(SC, 8'h02);
      rd_reg(EC, 8'h38);
      wr_reg(EC, 8'h00);
      rd_reg(EC, 8'h38);
   endtask : s_reset
   task automatic s_compat;
      hreq(COMPAT_BASE, 1, 0, ROUTE_HUB, 0);
      wr_reg(SC, 8'h0D);
      rd_reg(SC, 8'h0A);
      hreq(COMPAT_LAST, 1, 0, ROUTE_DRAM, COMPAT_LAST);
      hreq(COMPAT_BASE, 0, 0, ROUTE_HUB, 0);
      wr_reg(SC, 8'h28);
      hreq(COMPAT_BASE, 1, 0, ROUTE_HUB, 0);
      hreq(COMPAT_BASE, 1, 1, ROUTE_DRAM, COMPAT_BASE);
      wr_reg(SC, 8'h48);
      hreq(COMPAT_BASE, 0, 0, ROUTE_DRAM, COMPAT_BASE);
      wr_reg(SC, 8'h40);
      hreq(COMPAT_BASE, 0, 0, ROUTE_HUB, 0);
   endtask : s_compat
   task automatic s_high;
      wr_reg(SC, 8'h08);
      wr_reg(EC, 8'h80);
      host_model_i.issue(HIGH_BASE, 1, 0);
      chk("route", {30'h0, ROUTE_DRAM}, {30'h0, dec.route});
      chk("dram_addr", COMPAT_BASE, dec.dram_addr);
      chk("wb_cacheable", 1, {31'h0, wb});
      host_model_i.idle();
      hreq(HIGH_LAST, 1, 0, ROUTE_DRAM, COMPAT_LAST);
      host_model_i.issue(HIGH_BASE, 0, 0);
      chk("ext_error", 1, {31'h0, err});
      host_model_i.idle();
      wr_reg(EC, 8'h80);
      chk("ext_error", 1, {31'h0, err});
      wr_reg(EC, 8'hC0);
      chk("ext_error", 0, {31'h0, err});
      wr_reg(SC, 8'h00);
      hreq(HIGH_BASE, 1, 0, ROUTE_HUB, 0);
   endtask : s_high
   task automatic s_tseg;
      logic [31:0] b;
      wr_reg(SC, 8'h08);
      for (int k = 0; k < 4; k++) begin
         b = top_of_memory - (TSEG_128K << k);
         wr_reg(EC, 8'h01 | 8'(k << 1));
         hreq(b, 1, 0, ROUTE_DRAM, b);
         hreq(b - 1, 0, 0, ROUTE_DRAM, b - 1);
         hreq(b, 0, 0, ROUTE_HUB, 0);
      end
      chk("ext_error", 1, {31'h0, err});
   endtask : s_tseg
   task automatic s_lock;
      wr_reg(EC, 8'h47);
      wr_reg(SC, 8'h48);
      wr_reg(SC, 8'h18);
      rd_reg(SC, 8'h1A);
      wr_reg(SC, 8'h00);
      wr_reg(EC, 8'h80);
      rd_reg(SC, 8'h1A);
      rd_reg(EC, 8'h3F);
      nrst = 1'b0;
      @(negedge clk);
      nrst = 1'b1;
      rd_reg(SC, 8'h02);
      rd_reg(EC, 8'h38);
   endtask : s_lock
   task automatic s_freeze;
      ce = 1'b0;
      wr_reg(EC, 8'h81);
      ce = 1'b1;
      rd_reg(EC, 8'h38);
   endtask : s_freeze
   task automatic report_and_stop;
      if (n_fail == 0 && n_tests > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : report_and_stop
   initial begin
      repeat (12) @(negedge clk);
      nrst = 1'b1;
      s_reset();
      s_compat();
      s_high();
      s_tseg();
      s_lock();
      s_freeze();
      report_and_stop();
   end
endmodule : test_smram_access_decode
`default_nettype wire
